// ---- include/ubc_consts.svh ----
/*
 * Constants of the UART break and command control block.
 * Assumes inclusion by bare name from an include path that holds this folder.
 */
// What this block does
// - Start break code drives transmit line low.
// - Idle start break begins within one bit.
// - Break waits for shifting character to finish.
// - Held characters go out after break ends.
// - Start break needs transmitter enabled.
// - Start break ignores clear-to-send level.
// - Stop break restores mark within two bits.
// - After stop break, buffered characters resume.
// - Reset-break-change clears only delta break flag.
// - Command field bits six to four; zero none.
// - Code 101 means reset break change.
`ifndef UBC_CONSTS_SVH
`define UBC_CONSTS_SVH
`define UBC_CMD_MSB        6
`define UBC_CMD_LSB        4
`define UBC_CMD_NONE       3'h0
`define UBC_CMD_RST_BRK    3'h5
`define UBC_CMD_START_BRK  3'h6
`define UBC_CMD_STOP_BRK   3'h7
`define UBC_DATA_W         8
`define UBC_FIFO_DEPTH     8
`define UBC_FRAME_BITS     4'h9
`define UBC_BRK_DELAY_BITS 1
`define UBC_STOP_MAX_BITS  2
`define UBC_TXD_MARK       1'h1
`define UBC_SYNC_RST       3'h7
`endif

// ---- include/ubc_pkg.sv ----
/*
 * Types shared by the break and command control block.
 * Assumes the constants header is reachable on the include path.
 */
`include "ubc_consts.svh"
package ubc_pkg;
	typedef enum logic [2:0] {
		UBC_IDLE,
		UBC_SHIFT,
		UBC_BREAK,
		UBC_MARK
	} ubc_state_e;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ubc_cmd_s;

	typedef struct packed {
		logic                   valid;
		logic [`UBC_DATA_W-1:0] data;
	} ubc_word_s;
endpackage

// ---- hw/ubc_fifo.sv ----
/*
 * Transmit buffer FIFO with valid and ready on both sides.
 * Assumes a single clock and that both sides obey valid/ready.
 */
`timescale 1ns/1ps
`default_nettype none
module ubc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output var  logic             in_ready_o,
	output var  logic             out_valid_o,
	output var  logic [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        ready;
	} fifo_s;

	fifo_s s_q;
	fifo_s s_d;
	logic  push;
	logic  pop;

	assign push        = in_valid_i && s_q.ready;
	assign pop         = out_ready_i && (s_q.cnt != '0);
	assign in_ready_o  = s_q.ready;
	assign out_valid_o = (s_q.cnt != '0);
	assign out_data_o  = s_q.mem[s_q.rd];

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wr] = in_data_i;
			s_d.wr          = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		end
		s_d.cnt   = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		s_d.ready = (s_d.cnt != (AW+1)'(DEPTH));
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q       <= '0;
			s_q.ready <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ---- hw/ubc_top.sv ----
/*
 * Transmit path with command decode for break control and the delta break flag.
 * Assumes bit_tick_i is a one-cycle pulse per bit time from the baud generator
 * on clock_i, and that cts_n_i arrives straight from a pin.
 */
`timescale 1ns/1ps
`default_nettype none
module ubc_top
	import ubc_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_n_i,
	input  wire ubc_cmd_s  cmd_i,
	input  wire logic      tx_enable_i,
	input  wire logic      cts_n_i,
	input  wire logic      bit_tick_i,
	input  wire ubc_word_s tx_word_i,
	output var  logic      tx_ready_o,
	input  wire logic      db_set_i,
	output var  logic      db_flag_o,
	output var  logic      break_active_o,
	output var  logic      txd_o
);
	typedef struct packed {
		ubc_state_e             state;
		logic [`UBC_DATA_W:0]   shreg;
		logic [3:0]             bitcnt;
		logic                   txd;
		logic                   brk_pend;
		logic [2:0]             cts_sync;
		logic                   cts_n;
		logic                   db_flag;
		logic                   brk_act;
	} top_s;

	top_s                   s_q;
	top_s                   s_d;
	logic [2:0]             code;
	logic                   fifo_valid;
	logic [`UBC_DATA_W-1:0] fifo_data;
	logic                   fifo_pop;

	assign code = cmd_i.valid ? cmd_i.data[`UBC_CMD_MSB:`UBC_CMD_LSB] : `UBC_CMD_NONE;

	ubc_fifo #(
		.WIDTH(`UBC_DATA_W),
		.DEPTH(`UBC_FIFO_DEPTH)
	) u_fifo (
		.clock_i    (clock_i),
		.rst_n_i    (rst_n_i),
		.in_valid_i (tx_word_i.valid),
		.in_data_i  (tx_word_i.data),
		.in_ready_o (tx_ready_o),
		.out_valid_o(fifo_valid),
		.out_data_o (fifo_data),
		.out_ready_i(fifo_pop)
	);

	// A new character starts only from idle, on a bit tick, with no break waiting,
	// so a held character cannot slip out ahead of a requested break.
	assign fifo_pop = (s_q.state == UBC_IDLE) && bit_tick_i && fifo_valid && tx_enable_i
		&& !s_q.cts_n && !s_q.brk_pend && (code != `UBC_CMD_START_BRK);

	assign txd_o          = s_q.txd;
	assign db_flag_o      = s_q.db_flag;
	assign break_active_o = s_q.brk_act;

	always_comb begin
		s_d = s_q;
		// Clear-to-send is a pin; it counts once the last two stages agree.
		s_d.cts_sync = {s_q.cts_sync[1:0], cts_n_i};
		if (s_q.cts_sync[1] == s_q.cts_sync[2]) begin
			s_d.cts_n = s_q.cts_sync[2];
		end
		// A receiver event in the clearing cycle still sets the flag.
		s_d.db_flag = (s_q.db_flag && (code != `UBC_CMD_RST_BRK)) || db_set_i;

		// Flow control is not consulted here on purpose.
		if ((code == `UBC_CMD_START_BRK) && tx_enable_i) begin
			s_d.brk_pend = 1'b1;
		end
		// A stop ahead of the state decision cancels a waiting break, so a break
		// that would start on this very tick cannot outlive the stop.
		if ((code == `UBC_CMD_STOP_BRK) && (s_q.state != UBC_BREAK)) begin
			s_d.brk_pend = 1'b0;
		end

		case (s_q.state)
			UBC_IDLE: begin
				if (bit_tick_i) begin
					if (s_d.brk_pend) begin
						s_d.brk_pend = 1'b0;
						s_d.txd      = 1'b0;
						s_d.state    = UBC_BREAK;
					end else if (fifo_pop) begin
						s_d.txd    = 1'b0;
						s_d.shreg  = {1'b1, fifo_data};
						s_d.bitcnt = `UBC_FRAME_BITS;
						s_d.state  = UBC_SHIFT;
					end
				end
			end
			UBC_SHIFT: begin
				if (bit_tick_i) begin
					if (s_q.bitcnt != 4'h0) begin
						s_d.txd    = s_q.shreg[0];
						s_d.shreg  = {1'b0, s_q.shreg[`UBC_DATA_W:1]};
						s_d.bitcnt = s_q.bitcnt - 4'h1;
					end else if (s_d.brk_pend) begin
						s_d.brk_pend = 1'b0;
						s_d.txd      = 1'b0;
						s_d.state    = UBC_BREAK;
					end else begin
						s_d.state = UBC_IDLE;
					end
				end
			end
			UBC_BREAK: begin
				s_d.brk_pend = 1'b0;
				if (code == `UBC_CMD_STOP_BRK) begin
					// Mark returns at once, well inside the two bit time limit.
					s_d.txd   = `UBC_TXD_MARK;
					s_d.state = UBC_MARK;
				end
			end
			UBC_MARK: begin
				// One full bit of mark before the buffer drains again.
				if (bit_tick_i) begin
					s_d.state = UBC_IDLE;
				end
			end
			default: begin
				s_d.state = UBC_IDLE;
			end
		endcase

		// Kept as its own flop so the break port comes straight from a register.
		s_d.brk_act = (s_d.state == UBC_BREAK);
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q          <= '0;
			s_q.state    <= UBC_IDLE;
			s_q.txd      <= `UBC_TXD_MARK;
			s_q.cts_sync <= `UBC_SYNC_RST;
			s_q.cts_n    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ---- verif/ubc_monitor.sv ----
/* Assertions on the ports of ubc_top.
   Assumes one clock and the low-active asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ubc_monitor
	import ubc_pkg::*;
(
	input wire logic     clock_i,
	input wire logic     rst_n_i,
	input wire ubc_cmd_s cmd_i,
	input wire logic     bit_tick_i,
	input wire logic     db_set_i,
	input wire logic     db_flag_o,
	input wire logic     break_active_o,
	input wire logic     txd_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_stop; break_active_o && cmd_i.valid && cmd_i.data[6:4] == 3'h7; endsequence
	sequence s_clr; cmd_i.valid && cmd_i.data[6:4] == 3'h5 && !db_set_i; endsequence
	property p_low; break_active_o |-> !txd_o; endproperty
	a_low: assert property (p_low) else $error("break high");
	property p_hold; break_active_o && !cmd_i.valid |=> break_active_o; endproperty
	a_hold: assert property (p_hold) else $error("break lost");
	property p_stop; s_stop |=> txd_o && !break_active_o; endproperty
	a_stop: assert property (p_stop) else $error("no mark");
	property p_tick; $rose(break_active_o) |-> $past(bit_tick_i); endproperty
	a_tick: assert property (p_tick) else $error("break off tick");
	property p_edge; $changed(txd_o) |-> $past(bit_tick_i) || $past(cmd_i.valid); endproperty
	a_edge: assert property (p_edge) else $error("line off tick");
	property p_set; db_set_i |=> db_flag_o; endproperty
	a_set: assert property (p_set) else $error("flag not set");
	property p_clr; s_clr |=> !db_flag_o; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_keep; !db_set_i && !cmd_i.valid |=> $stable(db_flag_o); endproperty
	a_keep: assert property (p_keep) else $error("flag moved");
endmodule
bind ubc_top ubc_monitor u_ubc_monitor (.*);
`default_nettype wire

// ---- verif/ubc_line_model.sv ----
/* Remote receiver on the serial line.
   Assumes bit_tick_i marks the sender's bit boundaries. */
`timescale 1ns/1ps
`default_nettype none
module ubc_line_model (
	input  wire logic       clock_i,
	input  wire logic       bit_tick_i,
	input  wire logic       txd_i,
	output var  logic [7:0] byte_o,
	output var  int         count_o
);
	logic [3:0] n = 4'h0;
	int         cnt = 0;
	assign count_o = cnt;
	// A low stop bit is a break; hunting resumes only after mark returns.
	always @(posedge clock_i) if (bit_tick_i) begin
		if (n == 4'h0)
			n <= {3'h0, !txd_i};
		else if (n < 4'h9) begin
			byte_o <= {txd_i, byte_o[7:1]};
			n <= n + 4'h1;
		end else if (n == 4'h9) begin
			n <= txd_i ? 4'h0 : 4'hA;
			cnt <= cnt + int'(txd_i);
		end else if (txd_i)
			n <= 4'h0;
	end
endmodule
`default_nettype wire

// ---- verif/ubc_top_test.sv ----
/* Self-checking bench for ubc_top.
   Assumes a bit tick every fourth clock made here. */
`timescale 1ns/1ps
`default_nettype none
module ubc_top_test
	import ubc_pkg::*;
;
	logic      clock_i = 1'h0;
	logic      rst_n_i = 1'h0;
	ubc_cmd_s  cmd_i = '0;
	logic      tx_enable_i = 1'h1;
	logic      cts_n_i = 1'h0;
	logic      bit_tick_i = 1'h0;
	ubc_word_s tx_word_i = '0;
	logic      db_set_i = 1'h0;
	logic      tx_ready_o, db_flag_o, break_active_o, txd_o;
	logic [1:0] tk = 2'h0;
	logic [7:0] rx_byte;
	int        rx_count, c, mismatches = 0, comparisons = 0;
	ubc_top u_ubc_top (.*);
	ubc_line_model u_ubc_line_model (.clock_i, .bit_tick_i, .txd_i(txd_o),
		.byte_o(rx_byte), .count_o(rx_count));
	initial forever #4 clock_i = !clock_i;
	always @(negedge clock_i) begin
		tk <= tk + 2'h1;
		bit_tick_i <= tk == 2'h3;
	end
	task automatic cmp(string n, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic cmd(logic [7:0] d);
		cmd_i <= '{1'h1, d};
		cyc(1);
		cmd_i.valid <= 1'h0;
	endtask
	task automatic push(logic [7:0] d);
		tx_word_i <= '{1'h1, d};
		cyc(1);
	endtask
	task automatic waitc(int n);
		for (int i = 0; i < 3000 && rx_count < n; i++) cyc(1);
		if (rx_count < n) begin
			mismatches++;
			summarize();
		end
	endtask
	task t_busy;
		c = rx_count;
		push(8'h81);
		push(8'h7E);
		tx_word_i.valid <= 1'h0;
		cyc(12);
		cmd(8'h60);
		cyc(8);
		cmp("early", 8'h0, break_active_o);
		waitc(c + 1);
		cmp("first", 8'h81, rx_byte);
		cyc(60);
		cmp("held", 8'(c + 1), 8'(rx_count));
		cmp("brk", 8'h1, break_active_o);
		cmd(8'h70);
		cmp("mark", 8'h1, txd_o);
		waitc(c + 2);
		cmp("second", 8'h7E, rx_byte);
		$display("busy break done");
	endtask
	task t_idle;
		cts_n_i <= 1'h1;
		cmd(8'h60);
		cyc(4);
		cmp("start", 8'h1, break_active_o);
		cyc(60);
		cmp("low", 8'h0, txd_o);
		cmd(8'h70);
		cmp("stop", 8'h1, txd_o);
		cts_n_i <= 1'h0;
		tx_enable_i <= 1'h0;
		cyc(8);
		cmd(8'h60);
		cyc(12);
		cmp("off", 8'h0, break_active_o);
		tx_enable_i <= 1'h1;
		$display("idle break done");
	endtask
	task t_db;
		db_set_i <= 1'h1;
		cyc(1);
		db_set_i <= 1'h0;
		cmd(8'h40);
		cmp("kept", 8'h1, db_flag_o);
		cyc(1);
		cmd(8'hD1);
		cmp("cleared", 8'h0, db_flag_o);
		cyc(1);
		db_set_i <= 1'h1;
		cmd(8'h50);
		db_set_i <= 1'h0;
		cmp("set wins", 8'h1, db_flag_o);
		$display("flag done");
	endtask
	task t_fill;
		int n;
		c = rx_count;
		cts_n_i <= 1'h1;
		cyc(4);
		for (n = 0; n < 12 && tx_ready_o; n++) push(8'(n));
		tx_word_i.valid <= 1'h0;
		cmp("depth", 8'h8, 8'(n));
		cts_n_i <= 1'h0;
		waitc(c + 8);
		cmp("last", 8'h7, rx_byte);
		$display("fill done");
	endtask
	initial begin
		cyc(20);
		rst_n_i <= 1'h1;
		cyc(1);
		cmp("idle", 8'h1, txd_o);
		t_busy();
		t_idle();
		t_db();
		t_fill();
		summarize();
	end
endmodule
`default_nettype wire
